//--- data_phase_params.svh
// constants for the system bus data phase block
`ifndef DATA_PHASE_PARAMS_SVH
`define DATA_PHASE_PARAMS_SVH
`define DP_DATA_W        64
`define DP_GROUP_W       16
`define DP_GROUPS        4
`define DP_BEATS         4
`define DP_FIFO_DEPTH    8
`define DP_HALF_GROUP    8
`endif

//--- data_phase_pkg.sv
// types for the system bus data phase block
package data_phase_pkg;
  typedef logic [63:0] word_t;
  typedef logic [3:0]  group_bits_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DONE} tx_state_t;
endpackage

//--- word_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // word_fifo

//--- data_phase.sv
// data phase of the processor system bus: quad-pumped send and receive
`timescale 1ns/1ns
`include "data_phase_params.svh"
module data_phase
  import data_phase_pkg::*;
#(
  parameter int DATA_W = `DP_DATA_W,
  parameter int DEPTH  = `DP_FIFO_DEPTH
) (
  // core clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // link clock, four times the bus clock, runs free
  input  wire logic                      link_clk,
  input  wire logic                      link_rst,
  // user send side, one word per beat, four beats a phase
  input  wire logic                      send_valid,
  output logic                           send_ready,
  input  wire data_phase_pkg::word_t     send_data,
  // user receive side
  output logic                           recv_valid,
  output data_phase_pkg::word_t          recv_data,
  output logic                           order_input_a_seen,
  // bus data lines, active low
  input  wire data_phase_pkg::word_t     data_n_in,
  output data_phase_pkg::word_t          data_n_out,
  output logic                           data_n_oe,
  // strobes and inversion flags, active low
  input  wire data_phase_pkg::group_bits_t data_strobe_pos_n_in,
  input  wire data_phase_pkg::group_bits_t data_strobe_neg_n_in,
  output data_phase_pkg::group_bits_t    data_strobe_pos_n_out,
  output data_phase_pkg::group_bits_t    data_strobe_neg_n_out,
  output logic                           strobe_oe,
  input  wire data_phase_pkg::group_bits_t group_invert_flag_n_in,
  output data_phase_pkg::group_bits_t    group_invert_flag_n_out,
  // bus control, active low
  input  wire logic                      data_valid_signal_n_in,
  output logic                           data_valid_signal_n_out,
  input  wire logic                      data_bus_in_use_n_in,
  output logic                           data_bus_in_use_n_out,
  output logic                           ctrl_oe,
  input  wire logic                      order_input_a_n
);
  import data_phase_pkg::*;

  // send path: fifo on ref_clk, words staged for the link
  logic          fifo_valid;
  logic          fifo_ready;
  word_t         fifo_data;
  word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_valid  (send_valid),
    .in_ready  (send_ready),
    .in_data   (send_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // four-word staging, handed to the link by a toggle handshake
  word_t         stage [`DP_BEATS];
  logic [1:0]    stage_cnt;
  logic          stage_full;
  logic          req_tgl;
  logic          ack_s1;
  logic          ack_s2;
  logic          ack_tgl;
  wire           ack_done = ack_s2 == req_tgl;
  assign fifo_ready = !stage_full;
  always_ff @(posedge ref_clk) begin
    if (fifo_valid && fifo_ready) begin
      stage[stage_cnt] <= fifo_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_cnt  <= '0;
      stage_full <= 1'b0;
      req_tgl    <= 1'b0;
      ack_s1     <= 1'b0;
      ack_s2     <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      if (fifo_valid && fifo_ready) begin
        stage_cnt <= stage_cnt + 2'h1;
        if (stage_cnt == 2'h3) begin
          stage_full <= 1'b1;
          req_tgl    <= !req_tgl;
        end
      end else if (stage_full && ack_done) begin
        stage_full <= 1'b0;
      end
    end
  end

  // link domain transmitter
  logic          req_s1;
  logic          req_s2;
  logic          req_seen;
  logic          busy_s1;
  logic          busy_s2;
  tx_state_t     tx_state;
  logic [1:0]    beat;
  word_t         last_word;
  wire           new_req = req_s2 != req_seen;
  wire           bus_free = busy_s2;
  word_t         raw_word;
  word_t         toggles;
  group_bits_t   inv;
  word_t         line_word;
  assign raw_word = stage[beat];
  assign toggles  = raw_word ^ last_word;
  genvar g;
  generate
    for (g = 0; g < `DP_GROUPS; g++) begin : g_inv
      assign inv[g] = $countones(toggles[g*`DP_GROUP_W +: `DP_GROUP_W]) > `DP_HALF_GROUP;
      assign line_word[g*`DP_GROUP_W +: `DP_GROUP_W] =
        inv[g] ? ~raw_word[g*`DP_GROUP_W +: `DP_GROUP_W]
               :  raw_word[g*`DP_GROUP_W +: `DP_GROUP_W];
    end
  endgenerate

  // two-flop crossings into the link domain
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
    end else begin
      req_s1  <= req_tgl;
      req_s2  <= req_s1;
      busy_s1 <= data_bus_in_use_n_in;
      busy_s2 <= busy_s1;
    end
  end

  wire           in_send = tx_state == TX_SEND;
  wire           in_done = tx_state == TX_DONE;
  wire           strobe_phase = beat[0];

  // phase sequencing
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      tx_state  <= TX_IDLE;
      beat      <= '0;
      req_seen  <= 1'b0;
      ack_tgl   <= 1'b0;
      last_word <= '0;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (new_req && bus_free) begin
            tx_state <= TX_SEND;
            beat     <= '0;
          end
        end
        TX_SEND: begin
          last_word <= raw_word;
          beat <= beat + 2'h1;
          if (beat == 2'h3) begin
            tx_state <= TX_DONE;
          end
        end
        TX_DONE: begin
          req_seen <= req_s2;
          ack_tgl  <= req_s2;
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // pin drive, registered from the state
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      data_n_out              <= '1;
      data_n_oe               <= 1'b0;
      group_invert_flag_n_out <= '1;
      data_strobe_pos_n_out   <= '1;
      data_strobe_neg_n_out   <= '1;
      strobe_oe               <= 1'b0;
      ctrl_oe                 <= 1'b0;
    end else begin
      data_n_oe <= in_send;
      // strobes and control stay driven high one cycle after the phase
      strobe_oe <= in_send || in_done;
      ctrl_oe   <= in_send || in_done;
      if (in_send) begin
        data_n_out              <= ~line_word;
        group_invert_flag_n_out <= ~inv;
        data_strobe_pos_n_out   <= strobe_phase ? '1 : '0;
        data_strobe_neg_n_out   <= strobe_phase ? '0 : '1;
      end else begin
        group_invert_flag_n_out <= '1;
        data_strobe_pos_n_out   <= '1;
        data_strobe_neg_n_out   <= '1;
      end
    end
  end

  // bus control lines
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      data_valid_signal_n_out <= 1'b1;
      data_bus_in_use_n_out   <= 1'b1;
    end else begin
      data_valid_signal_n_out <= !in_send;
      data_bus_in_use_n_out   <= !in_send;
    end
  end

  // ---------- link domain receiver ----------
  logic          rx_active;
  logic [1:0]    rx_beat;
  word_t         rx_word;
  logic          rx_tgl;
  group_bits_t   rx_inv;
  word_t         rx_plain;
  generate
    for (g = 0; g < `DP_GROUPS; g++) begin : g_rx
      assign rx_inv[g] = !group_invert_flag_n_in[g];
      assign rx_plain[g*`DP_GROUP_W +: `DP_GROUP_W] =
        rx_inv[g] ? data_n_in[g*`DP_GROUP_W +: `DP_GROUP_W]
                  : ~data_n_in[g*`DP_GROUP_W +: `DP_GROUP_W];
    end
  endgenerate
  wire           strobe_hit = (data_strobe_pos_n_in == '0) || (data_strobe_neg_n_in == '0);
  assign rx_active = !data_valid_signal_n_in && !data_n_oe && strobe_hit;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_beat <= '0;
      rx_word <= '0;
      rx_tgl  <= 1'b0;
    end else if (rx_active) begin
      rx_word <= rx_plain;
      rx_beat <= rx_beat + 2'h1;
      rx_tgl  <= !rx_tgl;
    end
  end

  // receive word crossing: toggle plus held word, sampled after sync
  logic          rtg_s1;
  logic          rtg_s2;
  logic          rtg_s3;
  logic          def_s1;
  logic          def_s2;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rtg_s1     <= 1'b0;
      rtg_s2     <= 1'b0;
      rtg_s3     <= 1'b0;
      recv_valid <= 1'b0;
      recv_data  <= '0;
    end else begin
      rtg_s1     <= rx_tgl;
      rtg_s2     <= rtg_s1;
      rtg_s3     <= rtg_s2;
      recv_valid <= rtg_s2 != rtg_s3;
      if (rtg_s2 != rtg_s3) begin
        recv_data <= rx_word;
      end
    end
  end

  // order_input_a input, two flops then a level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      def_s1     <= 1'b1;
      def_s2     <= 1'b1;
      order_input_a_seen <= 1'b0;
    end else begin
      def_s1 <= order_input_a_n;
      def_s2 <= def_s1;
      order_input_a_seen <= !def_s2;
    end
  end
endmodule // data_phase

//--- data_phase_checker.sv
// port assertions for the data phase block
`timescale 1ns/1ns
module data_phase_checker
  import data_phase_pkg::*;
(
  // clocks and resets
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        link_clk,
  input wire logic        link_rst,
  // watched ports
  input wire logic        recv_valid,
  input wire logic        order_input_a_seen,
  input wire logic        order_input_a_n,
  input wire logic        data_n_oe,
  input wire logic        strobe_oe,
  input wire logic        ctrl_oe,
  input wire group_bits_t data_strobe_pos_n_out,
  input wire group_bits_t data_strobe_neg_n_out,
  input wire logic        data_valid_signal_n_out,
  input wire logic        data_bus_in_use_n_out
);
  chk_valid_owns_bus: assert property (@(posedge link_clk) disable iff (link_rst)
    !data_valid_signal_n_out |-> !data_bus_in_use_n_out && data_n_oe && ctrl_oe)
    else $error("valid without bus ownership");
  chk_use_four_beats: assert property (@(posedge link_clk) disable iff (link_rst)
    $fell(data_bus_in_use_n_out) |-> (!data_bus_in_use_n_out)[*4] ##1 data_bus_in_use_n_out)
    else $error("in-use not held four beats");
  chk_valid_each_beat: assert property (@(posedge link_clk) disable iff (link_rst)
    $fell(data_bus_in_use_n_out) |-> (!data_valid_signal_n_out)[*4])
    else $error("beat without valid");
  chk_strobe_order: assert property (@(posedge link_clk) disable iff (link_rst)
    $fell(data_bus_in_use_n_out) |-> strobe_oe && data_strobe_pos_n_out == 4'h0
    ##1 data_strobe_neg_n_out == 4'h0)
    else $error("strobe order wrong");
  chk_release_idle: assert property (@(posedge link_clk) disable iff (link_rst)
    $rose(data_bus_in_use_n_out) |-> !data_n_oe && data_valid_signal_n_out)
    else $error("lines driven after release");
  chk_idle_no_drive: assert property (@(posedge link_clk) disable iff (link_rst)
    data_bus_in_use_n_out |-> !data_n_oe)
    else $error("drive without in-use");
  chk_recv_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    recv_valid |=> !recv_valid)
    else $error("receive pulse too long");
  chk_order_input_a_set: assert property (@(posedge ref_clk) disable iff (rst)
    (!order_input_a_n)[*5] |-> order_input_a_seen)
    else $error("order_input_a not seen");
  chk_order_input_a_clear: assert property (@(posedge ref_clk) disable iff (rst)
    order_input_a_n[*5] |-> !order_input_a_seen)
    else $error("order_input_a stuck");
endmodule // data_phase_checker
bind data_phase data_phase_checker chk_u (.*);

//--- bus_agent_model.sv
// far-side bus agent on the link clock
`timescale 1ns/1ns
module bus_agent_model
  import data_phase_pkg::*;
(
  // link clock and design drive
  input  wire logic        link_clk,
  input  wire word_t       dut_data_n,
  input  wire group_bits_t dut_flag_n,
  input  wire logic        dut_valid_n,
  // own drive, terminated high when idle
  output word_t            p_data_n = '1,
  output group_bits_t      p_flag_n = '1,
  output group_bits_t      p_pos_n = '1,
  output group_bits_t      p_neg_n = '1,
  output logic             p_valid_n = 1'b1,
  output logic             p_use_n = 1'b1
);
  word_t got[$];
  group_bits_t got_flag[$];
  word_t prev = '0;
  function automatic word_t flip(word_t w, group_bits_t f);
    for (int g = 0; g < 4; g++)
      w[16*g+:16] = f[g] ? ~w[16*g+:16] : w[16*g+:16];
    return w;
  endfunction
  always @(negedge link_clk) begin
    if (dut_valid_n === 1'b0) begin
      got.push_back(flip(dut_data_n, dut_flag_n));
      got_flag.push_back(dut_flag_n);
    end
  end
  task automatic send(word_t w, bit pos);
    group_bits_t f;
    for (int g = 0; g < 4; g++)
      f[g] = !($countones(w[16*g+:16] ^ prev[16*g+:16]) > 8);
    prev = w;
    @(posedge link_clk);
    #1;
    p_use_n = 1'b0;
    p_valid_n = 1'b0;
    p_flag_n = f;
    p_data_n = flip(w, f);
    if (pos) p_pos_n = '0;
    else p_neg_n = '0;
    @(posedge link_clk);
    #1;
    {p_use_n, p_valid_n, p_flag_n, p_pos_n, p_neg_n, p_data_n} = '1;
    repeat (40) @(posedge link_clk);
  endtask
endmodule // bus_agent_model

//--- system_bus_data_phase_test.sv
// self-checking bench for the data phase block
`timescale 1ns/1ns
module system_bus_data_phase_test;
  import data_phase_pkg::*;
  logic ref_clk = 0, rst = 1, link_clk = 0, link_rst = 1;
  logic send_valid = 0, order_input_a_n = 1, other_n = 1;
  word_t send_data = '0, p_data, data_n_in, data_n_out, recv_data, w;
  group_bits_t p_flag, p_pos, p_neg, group_invert_flag_n_out, group_invert_flag_n_in;
  group_bits_t data_strobe_pos_n_in, data_strobe_neg_n_in;
  group_bits_t data_strobe_pos_n_out, data_strobe_neg_n_out;
  logic send_ready, recv_valid, order_input_a_seen, data_n_oe, strobe_oe, ctrl_oe, p_valid, p_use;
  logic data_valid_signal_n_in, data_valid_signal_n_out;
  logic data_bus_in_use_n_in, data_bus_in_use_n_out;
  word_t sent[$], rcvd[$], exp_rx[4];
  int n_errors = 0, checks_done = 0, n;
  word_t corner[4] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h00FF_0F0F_5555_AAAA,
                       64'hFFFF_0000_FFFF_0000};
  always #25 ref_clk = ~ref_clk;
  always #3 link_clk = ~link_clk;
  assign data_n_in = data_n_oe ? data_n_out : p_data;
  assign group_invert_flag_n_in = data_n_oe ? group_invert_flag_n_out : p_flag;
  assign data_strobe_pos_n_in = strobe_oe ? data_strobe_pos_n_out : p_pos;
  assign data_strobe_neg_n_in = strobe_oe ? data_strobe_neg_n_out : p_neg;
  assign data_valid_signal_n_in = (ctrl_oe ? data_valid_signal_n_out : 1'b1) & p_valid;
  assign data_bus_in_use_n_in = (ctrl_oe ? data_bus_in_use_n_out : 1'b1) & p_use & other_n;
  data_phase dut_u (.*);
  bus_agent_model agent_u (.link_clk(link_clk), .dut_data_n(data_n_out),
    .dut_flag_n(group_invert_flag_n_out), .dut_valid_n(data_valid_signal_n_out),
    .p_data_n(p_data), .p_flag_n(p_flag), .p_pos_n(p_pos), .p_neg_n(p_neg),
    .p_valid_n(p_valid), .p_use_n(p_use));
  always @(posedge ref_clk) if (recv_valid === 1'b1) rcvd.push_back(recv_data);
  task automatic check(bit ok, string msg);
    checks_done++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic push(word_t v);
    send_valid = 1'b1;
    send_data = v;
    sent.push_back(v);
    while (send_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  function automatic group_bits_t exp_flag(word_t v, word_t p);
    for (int g = 0; g < 4; g++) exp_flag[g] = $countones(v[16*g+:16] ^ p[16*g+:16]) <= 8;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(98828));
    repeat (4) @(negedge ref_clk);
    rst = 0;
    link_rst = 0;
    // other agent owns the bus while the fifo fills
    other_n = 0;
    while (send_ready === 1'b1 && sent.size() < 20)
      push(sent.size() < 4 ? corner[sent.size()] : {$urandom, $urandom});
    check(sent.size() >= 8 && data_n_oe === 1'b0, "sent while bus owned");
    other_n = 1;
    while (sent.size() % 4 != 0 || sent.size() < 20) push({$urandom, $urandom});
    send_valid = 1'b0;
    n = 0;
    while (agent_u.got.size() < sent.size() && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    check(agent_u.got.size() == sent.size(), "send count");
    foreach (sent[i]) check(agent_u.got[i] === sent[i], "send word");
    foreach (sent[i]) check(agent_u.got_flag[i] === exp_flag(sent[i], i ? sent[i-1] : '0), "flag");
    // far side sends spaced single beats, alternating strobes
    for (int i = 0; i < 4; i++) begin
      exp_rx[i] = i < 2 ? corner[3 - i] : {$urandom, $urandom};
      agent_u.send(exp_rx[i], i % 2 == 0);
    end
    repeat (10) @(negedge ref_clk);
    check(rcvd.size() == 4, "receive count");
    foreach (exp_rx[i]) check(rcvd[i] === exp_rx[i], "receive word");
    order_input_a_n = 0;
    repeat (8) @(negedge ref_clk);
    check(order_input_a_seen === 1'b1, "order_input_a missed");
    order_input_a_n = 1;
    repeat (8) @(negedge ref_clk);
    check(order_input_a_seen === 1'b0, "order_input_a stuck");
    tally_and_finish;
  end
endmodule // system_bus_data_phase_test
